// >>> src/mpc_meter_pwm.sv
// mpc_meter_pwm: two meter counters, six meter channels and their register file.
// assumes a byte bus whose strobes last one cycle and are synchronous to mclk.
`timescale 1ns/1ps
module mpc_meter_pwm
	import mpc_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// register bus
	input wire logic [15:0] bus_addr,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [7:0] bus_wdata,
	output logic [7:0] bus_rdata,
	// external count clock pin
	input wire logic external_timer_clock_in,
	// meter coil pins, four per meter
	output logic [NUM_METERS*PINS_PER_METER-1:0] meter_pins
);
	// address of a compare value byte, side 0 sine, side 1 cosine
	function automatic logic [15:0] cmp_val_addr(input int idx, input int side);
		cmp_val_addr = ADDR_CMP_VAL_BASE + 16'(idx) * ADDR_CMP_VAL_STRIDE + 16'(side);
	endfunction : cmp_val_addr

	// counter control registers and time base
	logic [7:0] cnt_ctrl_q [0:1];
	logic [7:0] cnt_q [0:1];
	logic [7:0] cnt_d [0:1];
	logic [1:0] tick;
	logic [1:0] ovf;
	logic [1:0] run;
	logic [1:0] full;
	logic master;
	logic wr_cc0;
	logic wr_cc1;
	logic [7:0] cc0_wval;
	logic [7:0] cc1_wval;

	// channel state
	logic [7:0] cmp_ctrl_q [0:NUM_METERS-1];
	logic [7:0] sin_m_q [0:NUM_METERS-1];
	logic [7:0] cos_m_q [0:NUM_METERS-1];
	logic [7:0] sin_s_q [0:NUM_METERS-1];
	logic [7:0] cos_s_q [0:NUM_METERS-1];
	logic [NUM_METERS-1:0] sdith_s_q;
	logic [NUM_METERS-1:0] cdith_s_q;
	logic [NUM_METERS-1:0] valid_q;
	logic [NUM_METERS-1:0] sin_lvl;
	logic [NUM_METERS-1:0] cos_lvl;
	logic [NUM_METERS-1:0] wr_ctrl;
	logic [NUM_METERS-1:0] wr_sin;
	logic [NUM_METERS-1:0] wr_cos;
	logic [NUM_METERS-1:0] ch_ovf;
	logic [NUM_METERS-1:0] ch_tick;
	logic [NUM_METERS-1:0] ch_run;
	logic [NUM_METERS*PINS_PER_METER-1:0] route;
	logic [NUM_METERS*PINS_PER_METER-1:0] pins_q;
	logic [7:0] rd_mux;
	logic [7:0] rdata_q;

	// counter control decode
	assign master = cnt_ctrl_q[0][CC_MASTER_BIT];
	assign wr_cc0 = bus_wr && (bus_addr == ADDR_CNT_CTRL0);
	assign wr_cc1 = bus_wr && (bus_addr == ADDR_CNT_CTRL1);
	assign cc0_wval = bus_wdata[CC_MASTER_BIT] ? (bus_wdata & CNT_CTRL0_MASK) : REG_RESET;
	assign cc1_wval = bus_wdata & CNT_CTRL1_MASK;

	// counter control 0 holds the master enable; disabling clears the rest
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ctrl_q[0] <= REG_RESET;
		end else if (wr_cc0) begin
			cnt_ctrl_q[0] <= cc0_wval; // see RULE1
		end
	end

	// counter control 1 is held in reset while the master enable is off
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ctrl_q[1] <= REG_RESET;
		end else if (!master || (wr_cc0 && !bus_wdata[CC_MASTER_BIT])) begin
			cnt_ctrl_q[1] <= REG_RESET; // see RULE1
		end else if (wr_cc1) begin
			cnt_ctrl_q[1] <= cc1_wval;
		end
	end

	// two time bases, each an 8-bit free running up counter
	for (genvar k = 0; k < 2; k++) begin : g_cnt
		assign run[k] = master & cnt_ctrl_q[k][CC_RUN_BIT]; // see RULE4
		assign full[k] = cnt_ctrl_q[k][CC_FULL_BIT];
		assign ovf[k] = tick[k] && (cnt_q[k] == CNT_TOP); // see RULE2 see RULE3

		mpc_tick_gen #(
			.DIV_W(8)
		) u_tick (
			.mclk(mclk),
			.rst_n(rst_n),
			.run(run[k]),
			.src_ext(cnt_ctrl_q[k][CC_SRC_BIT]),
			.pre_sel(cnt_ctrl_q[k][CC_PRE_LSB +: PRE_W]),
			.ext_clk_pin(external_timer_clock_in),
			.tick(tick[k])
		);

		// next count: clear when stopped, restart value depends on full mode
		assign cnt_d[k] = !run[k] ? CNT_CLEAR :
			!tick[k] ? cnt_q[k] :
			(cnt_q[k] == CNT_TOP) ? (full[k] ? CNT_FIRST_FULL : CNT_FIRST_NORM) :
			cnt_q[k] + 8'h01; // see RULE23 see RULE2 see RULE3 see RULE4

		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				cnt_q[k] <= CNT_CLEAR;
			end else begin
				cnt_q[k] <= cnt_d[k];
			end
		end
	end

	// meter channels
	for (genvar j = 0; j < NUM_METERS; j++) begin : g_ch
		localparam int CS = (j < METERS_ON_CNT0) ? 0 : 1;
		logic transfer_enable;
		logic mode;
		logic [1:0] quad;
		logic [3:0] r;

		assign transfer_enable = cmp_ctrl_q[j][CH_TEN_BIT];
		assign mode = cmp_ctrl_q[j][CH_MODE_BIT];
		assign quad = cmp_ctrl_q[j][CH_QUAD_LSB +: 2];
		assign ch_ovf[j] = ovf[CS];
		assign ch_tick[j] = tick[CS]; // see RULE21 see RULE22
		assign ch_run[j] = run[CS];
		// writes are refused while a transfer is armed
		assign wr_ctrl[j] = bus_wr && !transfer_enable && (bus_addr == ADDR_CMP_CTRL[j]); // see RULE11
		assign wr_sin[j] = bus_wr && !transfer_enable && (bus_addr == cmp_val_addr(j, 0)); // see RULE11
		assign wr_cos[j] = bus_wr && !transfer_enable && (bus_addr == cmp_val_addr(j, 1)); // see RULE11

		// control register; hardware clears the transfer flag at overflow
		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				cmp_ctrl_q[j] <= REG_RESET;
			end else if (!master) begin
				cmp_ctrl_q[j][CH_TEN_BIT] <= 1'b0; // see RULE1
			end else if (wr_ctrl[j]) begin
				cmp_ctrl_q[j] <= bus_wdata & CMP_CTRL_MASK; // see RULE11 see RULE13
			end else if (ch_ovf[j] && transfer_enable) begin
				cmp_ctrl_q[j][CH_TEN_BIT] <= 1'b0; // see RULE12
			end
		end

		// master compare latches
		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				sin_m_q[j] <= REG_RESET;
				cos_m_q[j] <= REG_RESET;
			end else begin
				if (wr_sin[j]) begin
					sin_m_q[j] <= bus_wdata;
				end
				if (wr_cos[j]) begin
					cos_m_q[j] <= bus_wdata;
				end
			end
		end

		// slave latches load at an armed overflow
		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				sin_s_q[j] <= REG_RESET;
				cos_s_q[j] <= REG_RESET;
				sdith_s_q[j] <= 1'b0;
				cdith_s_q[j] <= 1'b0;
				valid_q[j] <= 1'b0;
			end else if (!ch_run[j]) begin
				valid_q[j] <= 1'b0; // see RULE24
			end else if (ch_ovf[j] && transfer_enable) begin
				sin_s_q[j] <= sin_m_q[j]; // see RULE16
				cos_s_q[j] <= cos_m_q[j]; // see RULE16
				sdith_s_q[j] <= cmp_ctrl_q[j][CH_SDITH_BIT]; // see RULE13
				cdith_s_q[j] <= cmp_ctrl_q[j][CH_CDITH_BIT]; // see RULE13
				valid_q[j] <= 1'b1;
			end
		end

		mpc_pwm_side u_sin (
			.mclk(mclk),
			.rst_n(rst_n),
			.tick(ch_tick[j]),
			.ovf(ch_ovf[j]),
			.cnt_next(cnt_d[CS]),
			.valid(valid_q[j]),
			.cmp_val(sin_s_q[j]),
			.dither_en(sdith_s_q[j]),
			.level(sin_lvl[j])
		);

		mpc_pwm_side u_cos (
			.mclk(mclk),
			.rst_n(rst_n),
			.tick(ch_tick[j]),
			.ovf(ch_ovf[j]),
			.cnt_next(cnt_d[CS]),
			.valid(valid_q[j]),
			.cmp_val(cos_s_q[j]),
			.dither_en(cdith_s_q[j]),
			.level(cos_lvl[j])
		);

		// pin routing: mirror mode or quadrant selection, idle pins low
		assign r[PIN_SIN_P] = mode ? sin_lvl[j] :
			(quad == QUAD_1 || quad == QUAD_2) & sin_lvl[j]; // see RULE9 see RULE10 see RULE14
		assign r[PIN_SIN_N] = mode ? sin_lvl[j] :
			(quad == QUAD_3 || quad == QUAD_4) & sin_lvl[j]; // see RULE9 see RULE10 see RULE14
		assign r[PIN_COS_P] = mode ? cos_lvl[j] :
			(quad == QUAD_1 || quad == QUAD_4) & cos_lvl[j]; // see RULE9 see RULE10 see RULE14
		assign r[PIN_COS_N] = mode ? cos_lvl[j] :
			(quad == QUAD_2 || quad == QUAD_3) & cos_lvl[j]; // see RULE9 see RULE10 see RULE14
		assign route[j*PINS_PER_METER +: PINS_PER_METER] = r;

		// pins follow one count clock late to spread supply steps
		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				pins_q[j*PINS_PER_METER +: PINS_PER_METER] <= 4'h0;
			end else if (!master) begin
				pins_q[j*PINS_PER_METER +: PINS_PER_METER] <= 4'h0; // see RULE1
			end else if (ch_tick[j]) begin
				pins_q[j*PINS_PER_METER +: PINS_PER_METER] <= r; // see RULE21 see RULE22
			end
		end
	end

	assign meter_pins = pins_q;

	// read selection; unmapped addresses read zero
	always_comb begin
		rd_mux = 8'h00;
		if (bus_addr == ADDR_CNT_CTRL0) begin
			rd_mux = cnt_ctrl_q[0];
		end
		if (bus_addr == ADDR_CNT_CTRL1) begin
			rd_mux = cnt_ctrl_q[1];
		end
		for (int i = 0; i < NUM_METERS; i++) begin
			if (bus_addr == ADDR_CMP_CTRL[i]) begin
				rd_mux = cmp_ctrl_q[i];
			end
			if (bus_addr == cmp_val_addr(i, 0)) begin
				rd_mux = sin_m_q[i];
			end
			if (bus_addr == cmp_val_addr(i, 1)) begin
				rd_mux = cos_m_q[i];
			end
		end
	end

	// read data registered one cycle after the strobe
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 8'h00;
		end else if (bus_rd) begin
			rdata_q <= rd_mux;
		end
	end

	assign bus_rdata = rdata_q;

	// checks on channels 0, 2, 4 and 5 and both counters
	chk_master_off_clear: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE1
		$fell(master) |=> (cnt_q[0] == CNT_CLEAR) && (cnt_q[1] == CNT_CLEAR) &&
		(cnt_ctrl_q[1] == REG_RESET) && (meter_pins == '0))
		else $error("master disable did not stop both controllers");

	chk_norm_wrap: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE2
		ovf[0] && !full[0] && run[0] |=> cnt_q[0] == CNT_FIRST_NORM)
		else $error("normal mode did not restart at 01");

	chk_full_wrap: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE3
		ovf[0] && full[0] && run[0] |=> cnt_q[0] == CNT_FIRST_FULL)
		else $error("full mode did not wrap to 00");

	chk_run_clears: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE4
		$fell(run[0]) |=> (cnt_q[0] == CNT_CLEAR) [*2])
		else $error("stopped counter not cleared");

	chk_count_step: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE23
		tick[0] && run[0] && cnt_q[0] != CNT_TOP |=> cnt_q[0] == $past(cnt_q[0]) + 8'h01)
		else $error("counter did not step by one");

	chk_ten_cleared: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE12
		ovf[0] && cmp_ctrl_q[0][CH_TEN_BIT] && !$fell(master) && master
		|=> !cmp_ctrl_q[0][CH_TEN_BIT])
		else $error("transfer flag not cleared at overflow");

	chk_slave_load: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE16
		ovf[0] && run[0] && cmp_ctrl_q[0][CH_TEN_BIT]
		|=> sin_s_q[0] == $past(sin_m_q[0]) && cos_s_q[0] == $past(cos_m_q[0]) && valid_q[0])
		else $error("slave latches not loaded at overflow");

	chk_write_block: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE11
		bus_wr && cmp_ctrl_q[0][CH_TEN_BIT] |=> $stable(sin_m_q[0]) && $stable(cos_m_q[0]))
		else $error("compare value changed while transfer armed");

	chk_no_early_pulse: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE24
		!valid_q[0] |=> !sin_lvl[0] && !cos_lvl[0])
		else $error("pwm produced before first transfer");

	chk_pin_lag: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE21
		tick[0] && master |=> meter_pins[3:0] == $past(route[3:0]))
		else $error("meter 1 pins not one count late");

	chk_quad_idle: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE14
		!cmp_ctrl_q[0][CH_MODE_BIT] && cmp_ctrl_q[0][1:0] == 2'h0
		|-> !route[PIN_SIN_N] && !route[PIN_COS_N])
		else $error("quadrant 1 drove a negative pin");

	// first pin of meter 5, the first meter on counter 1
	localparam int M5_PIN0 = METERS_ON_CNT0 * PINS_PER_METER;

	chk_quad_off_pins: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE9
		!cmp_ctrl_q[2][CH_MODE_BIT] && cmp_ctrl_q[2][CH_QUAD_LSB +: 2] == QUAD_3
		|-> !route[2*PINS_PER_METER + PIN_SIN_P] && !route[2*PINS_PER_METER + PIN_COS_P])
		else $error("quadrant 3 drove a positive pin");

	chk_mirror_pairs: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE10
		cmp_ctrl_q[4][CH_MODE_BIT] && tick[1]
		|=> meter_pins[M5_PIN0 + PIN_SIN_P] == meter_pins[M5_PIN0 + PIN_SIN_N] &&
		meter_pins[M5_PIN0 + PIN_COS_P] == meter_pins[M5_PIN0 + PIN_COS_N])
		else $error("mirror mode pin pairs differ");

	chk_pin_lag_two: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE22
		tick[1] && master |=> meter_pins[M5_PIN0 +: 2*PINS_PER_METER] ==
		$past(route[M5_PIN0 +: 2*PINS_PER_METER]))
		else $error("meters 5 and 6 pins not one count late");

	chk_rise_at_ovf: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE20
		ovf[0] && valid_q[0] |=> sin_lvl[0] && cos_lvl[0])
		else $error("pwm level did not rise at overflow");

	cov_transfer: cover property (@(posedge mclk) disable iff (!rst_n)
		ovf[0] && cmp_ctrl_q[0][CH_TEN_BIT]);
	cov_dither_period: cover property (@(posedge mclk) disable iff (!rst_n)
		ovf[0] && sdith_s_q[0] && valid_q[0]);
	cov_mirror_mode: cover property (@(posedge mclk) disable iff (!rst_n)
		cmp_ctrl_q[0][CH_MODE_BIT] && sin_lvl[0]);
	cov_counter1_ovf: cover property (@(posedge mclk) disable iff (!rst_n)
		ovf[1] && cnt_ctrl_q[1][CC_SRC_BIT]);
endmodule : mpc_meter_pwm

// >>> src/mpc_pkg.sv
// mpc_pkg: register map, field positions and constants of the meter pwm controller.
// assumes an internal byte bus with 16-bit addresses and single-cycle strobes.
// Summary of operation
// RULE1: master enable off stops and resets counter controls
// RULE2: normal mode counts 01h to ffh, overflow ffh
// RULE3: full mode counts 00h to ffh, wraps 00h
// RULE4: run bit starts counting, clearing stops and clears
// RULE5: source bit picks prescaled or external clock
// RULE6: prescaler code divides clock by 2 to 256
// RULE7: software stops counter before changing its control
// RULE8: software writes zero to the unused control bits
// RULE9: mode 0 drives pwm on quadrant pins only
// RULE10: mode 1 mirrors sine and cosine onto pin pairs
// RULE11: transfer enable arms overflow load, blocks writes
// RULE12: hardware clears transfer enable at overflow
// RULE13: dither bits enable the sine and cosine addition
// RULE14: quadrant code selects sine and cosine pin polarity
// RULE15: software checks flag, writes data, sets flag
// RULE16: overflow copies compare data into slave latches
// RULE17: software rewrites channel control only while flag clear
// RULE18: dither alternates falling edge between N and N+1
// RULE19: without dither the edge is always at N+1
// RULE20: pwm level changes at each counter overflow
// RULE21: meters 1-4 pins lag one count of counter 0
// RULE22: meters 5-6 pins lag one count of counter 1
// RULE23: each counter is an 8-bit up counter
// RULE24: no pulse before first transfer after counting starts
// RULE25: pwm rises at overflow, falls at compare match
package mpc_pkg;
	localparam int NUM_METERS = 6;
	localparam int METERS_ON_CNT0 = 4;
	localparam int PINS_PER_METER = 4;
	// register byte addresses
	localparam logic [15:0] ADDR_CNT_CTRL0 = 16'hf180;
	localparam logic [15:0] ADDR_CNT_CTRL1 = 16'hf1a8;
	localparam logic [15:0] ADDR_CMP_CTRL [0:5] = '{16'hf194, 16'hf198, 16'hf19c,
		16'hf1a0, 16'hf1b4, 16'hf1b8};
	localparam logic [15:0] ADDR_CMP_VAL_BASE = 16'hf1c0;
	localparam logic [15:0] ADDR_CMP_VAL_STRIDE = 16'h0002;
	// counter control fields
	localparam int CC_MASTER_BIT = 7;
	localparam int CC_FULL_BIT = 5;
	localparam int CC_RUN_BIT = 4;
	localparam int CC_SRC_BIT = 3;
	localparam int CC_PRE_LSB = 0;
	localparam int PRE_W = 3;
	localparam logic [7:0] CNT_CTRL0_MASK = 8'hbf;
	localparam logic [7:0] CNT_CTRL1_MASK = 8'h3f;
	// channel compare control fields
	localparam int CH_MODE_BIT = 7;
	localparam int CH_TEN_BIT = 4;
	localparam int CH_CDITH_BIT = 3;
	localparam int CH_SDITH_BIT = 2;
	localparam int CH_QUAD_LSB = 0;
	localparam logic [7:0] CMP_CTRL_MASK = 8'h9f;
	localparam logic [7:0] REG_RESET = 8'h00;
	// counter values
	localparam logic [7:0] CNT_TOP = 8'hff;
	localparam logic [7:0] CNT_CLEAR = 8'h00;
	localparam logic [7:0] CNT_FIRST_NORM = 8'h01;
	localparam logic [7:0] CNT_FIRST_FULL = 8'h00;
	// pin order inside one meter
	localparam int PIN_SIN_P = 0;
	localparam int PIN_SIN_N = 1;
	localparam int PIN_COS_P = 2;
	localparam int PIN_COS_N = 3;
	typedef enum logic [1:0] {QUAD_1, QUAD_2, QUAD_3, QUAD_4} mpc_quad_t;
endpackage : mpc_pkg

// >>> src/mpc_tick_gen.sv
// mpc_tick_gen: count-clock enable of one counter, prescaled or from the external pin.
// assumes the external pin is asynchronous to mclk and slower than mclk/2.
`timescale 1ns/1ps
module mpc_tick_gen
	import mpc_pkg::*;
#(
	parameter int DIV_W = 8
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// configuration
	input wire logic run,
	input wire logic src_ext,
	input wire logic [PRE_W-1:0] pre_sel,
	// external clock pin
	input wire logic ext_clk_pin,
	// count enable
	output logic tick
);
	if (DIV_W < (1 << PRE_W))
		$error("mpc_tick_gen: DIV_W too small for prescaler codes");

	logic ext_s1_q;
	logic ext_s2_q;
	logic ext_s3_q;
	logic [DIV_W-1:0] div_q;
	logic [DIV_W-1:0] div_mask;
	logic ext_rise;
	logic div_hit;

	// two-stage synchroniser, third stage only for the edge
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			ext_s3_q <= 1'b0;
		end else begin
			ext_s1_q <= ext_clk_pin;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
		end
	end

	// divider runs only while counting so a start is phase clean
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			div_q <= '0;
		end else if (!run) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 1'b1;
		end
	end

	// code k divides by 2^(k+1)
	assign div_mask = {DIV_W{1'b1}} >> (DIV_W - 1 - int'(pre_sel)); // see RULE6
	assign div_hit = (div_q & div_mask) == div_mask;
	assign ext_rise = ext_s2_q & ~ext_s3_q;
	assign tick = run & (src_ext ? ext_rise : div_hit); // see RULE5
endmodule : mpc_tick_gen

// >>> src/mpc_pwm_side.sv
// mpc_pwm_side: pwm level of one coil side from the slave compare value.
// assumes ovf and tick come from the counter that this meter is tied to.
`timescale 1ns/1ps
module mpc_pwm_side (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// time base
	input wire logic tick,
	input wire logic ovf,
	input wire logic [7:0] cnt_next,
	// slave data
	input wire logic valid,
	input wire logic [7:0] cmp_val,
	input wire logic dither_en,
	// pwm level
	output logic level
);
	logic phase_q;
	logic [8:0] thr;

	// addition phase flips every overflow while dither is on
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			phase_q <= 1'b0;
		end else if (ovf) begin
			phase_q <= dither_en & ~phase_q; // see RULE18
		end
	end

	// falling point: N+1 normally, N on the non-added periods
	assign thr = (dither_en && !phase_q) ? {1'b0, cmp_val} : {1'b0, cmp_val} + 9'h001; // see RULE19

	// rises at overflow, falls at the match point
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			level <= 1'b0;
		end else if (!valid) begin
			level <= 1'b0; // see RULE24
		end else if (ovf) begin
			level <= 1'b1; // see RULE20 see RULE25
		end else if (tick && {1'b0, cnt_next} == thr) begin
			level <= 1'b0; // see RULE25
		end
	end
endmodule : mpc_pwm_side

// >>> bench/mpc_coil_model.sv
// mpc_coil_model: coil load on every meter pin that times whole pulses.
// assumes pins change only at mclk edges; clr restarts all timing.
`timescale 1ns/1ps
module mpc_coil_model (
	// clock
	input wire logic mclk,
	// coil pins and timing restart
	input wire logic [23:0] pins,
	input wire logic clr
);
	int cnt [24];
	int hi_run [24];
	int prev_hi [24];
	int lo_run [24];
	logic [23:0] last;
	// store each finished run of a pin, the last two high ones kept
	always @(posedge mclk) begin
		for (int i = 0; i < 24; i++) begin
			if (clr) begin
				cnt[i] = 0;
				hi_run[i] = 0;
				prev_hi[i] = 0;
				lo_run[i] = 0;
			end else if (pins[i] !== last[i]) begin
				if (last[i] === 1'b1) begin
					prev_hi[i] = hi_run[i];
					hi_run[i] = cnt[i];
				end else begin
					lo_run[i] = cnt[i];
				end
				cnt[i] = 1;
			end else begin
				cnt[i]++;
			end
		end
		last = pins;
	end
endmodule : mpc_coil_model

// >>> bench/mpc_meter_pwm_tb.sv
// mpc_meter_pwm_tb: self-checking bench with a register model and coil load.
// assumes mclk at 200 MHz; random compare values from a fixed seed.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin bad_count++; \
	$display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module mpc_meter_pwm_tb
	import mpc_pkg::*;
;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic bus_wr = 1'b0;
	logic bus_rd = 1'b0;
	logic ext = 1'b0;
	logic clr = 1'b0;
	logic [15:0] bus_addr = 16'h0000;
	logic [7:0] bus_wdata = 8'h00;
	logic [7:0] bus_rdata;
	logic [23:0] pins;
	logic [2:0] ediv = 3'h0;
	logic [7:0] mdl [logic [15:0]];
	int bad_count = 0;
	int samples_checked = 0;
	integer seed = 32'h70300b9f;
	localparam logic [15:0] VB = ADDR_CMP_VAL_BASE;

	// clock and external count clock, eight mclk per period
	always #2.5 mclk = ~mclk;
	always @(posedge mclk) begin
		ediv <= ediv + 3'h1;
		ext <= ediv[2];
	end

	mpc_meter_pwm DUT (.mclk(mclk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wr(bus_wr),
		.bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
		.external_timer_clock_in(ext), .meter_pins(pins));
	mpc_coil_model coil (.mclk(mclk), .pins(pins), .clr(clr));

	function automatic logic [7:0] rnd();
		logic [31:0] r;
		r = $random(seed);
		return 8'(2 + r % 252);
	endfunction : rnd

	function automatic int chan_of(input logic [15:0] a);
		chan_of = -1;
		for (int i = 0; i < NUM_METERS; i++) begin
			if (a == ADDR_CMP_CTRL[i] || a[15:1] == 15'((VB >> 1) + i))
				chan_of = i;
		end
	endfunction : chan_of

	// register model: locks, master clear and armed channels
	function automatic void mwr(input logic [15:0] a, input logic [7:0] d);
		int c;
		c = chan_of(a);
		if (a == ADDR_CNT_CTRL0 && !d[CC_MASTER_BIT]) begin
			mdl[a] = 8'h00;
			mdl[ADDR_CNT_CTRL1] = 8'h00;
			for (int i = 0; i < NUM_METERS; i++)
				mdl[ADDR_CMP_CTRL[i]][CH_TEN_BIT] = 1'b0;
		end else if (a == ADDR_CNT_CTRL0)
			mdl[a] = d & CNT_CTRL0_MASK;
		else if (a == ADDR_CNT_CTRL1 && mdl[ADDR_CNT_CTRL0][CC_MASTER_BIT])
			mdl[a] = d & CNT_CTRL1_MASK;
		else if (c >= 0 && !mdl[ADDR_CMP_CTRL[c]][CH_TEN_BIT])
			mdl[a] = (a == ADDR_CMP_CTRL[c]) ? d & CMP_CTRL_MASK : d;
	endfunction : mwr

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge mclk);
		bus_wr <= 1'b0;
		mwr(a, d);
	endtask : wr

	task automatic rd(input logic [15:0] a, output logic [7:0] v, input bit chk);
		@(posedge mclk);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge mclk);
		bus_rd <= 1'b0;
		#1 v = bus_rdata;
		if (chk)
			`CHK("register", (mdl.exists(a) ? mdl[a] : 8'h00), v)
	endtask : rd

	// poll until the overflow has taken the armed data
	task automatic wait_ten(input int m);
		logic [7:0] v;
		for (int i = 0; i < 3000; i++) begin
			rd(ADDR_CMP_CTRL[m], v, 0);
			if (v[CH_TEN_BIT] === 1'b0)
				break;
		end
		`CHK("transfer flag", 1'b0, v[CH_TEN_BIT])
		mdl[ADDR_CMP_CTRL[m]][CH_TEN_BIT] = 1'b0;
	endtask : wait_ten

	// load one meter, wait for transfer, then time all four coil pins
	task automatic run_chk(input int m, input logic [7:0] ctl, ns, nc, input int div, full,
		input bit load);
		logic [7:0] v;
		int n;
		int i;
		int q;
		int hi;
		bit act;
		bit dith;
		if (load) begin
			rd(ADDR_CMP_CTRL[m], v, 1);
			wr(VB + 16'(2 * m), ns);
			wr(VB + 16'(2 * m + 1), nc);
			wr(ADDR_CMP_CTRL[m], ctl | 8'h10);
		end
		wait_ten(m);
		@(posedge mclk) clr <= 1'b1;
		@(posedge mclk) clr <= 1'b0;
		repeat (4 * 256 * div) @(posedge mclk);
		#1;
		q = ctl[1:0];
		for (int p = 0; p < 4; p++) begin
			n = (p < 2) ? ns : nc;
			dith = (p < 2) ? ctl[CH_SDITH_BIT] : ctl[CH_CDITH_BIT];
			act = ctl[CH_MODE_BIT] || (p == 0 && q < 2) || (p == 1 && q >= 2) ||
				(p == 2 && (q == 0 || q == 3)) || (p == 3 && (q == 1 || q == 2));
			i = 4 * m + p;
			hi = act ? (n + full) * div : 0;
			if (act && dith)
				`CHK("dithered pair", (2 * n - 1) * div, coil.hi_run[i] + coil.prev_hi[i])
			else
				`CHK("pulse width", hi, coil.hi_run[i])
			if (act && !dith)
				`CHK("pulse gap", (255 + full) * div - hi, coil.lo_run[i])
		end
	endtask : run_chk

	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : close_out

	// main sequence
	initial begin
		logic [7:0] v;
		logic [7:0] n;
		mdl[ADDR_CNT_CTRL0] = REG_RESET;
		mdl[ADDR_CNT_CTRL1] = REG_RESET;
		for (int i = 0; i < 12; i++)
			mdl[VB + 16'(i)] = REG_RESET;
		for (int i = 0; i < NUM_METERS; i++)
			mdl[ADDR_CMP_CTRL[i]] = REG_RESET;
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		foreach (mdl[a])
			rd(a, v, 1);
		wr(16'hf184, 8'h5a);
		rd(16'hf184, v, 1);
		$display("test reset done");
		// counter 1 control stays locked until the master enable is on
		wr(ADDR_CNT_CTRL1, 8'h11);
		rd(ADDR_CNT_CTRL1, v, 1);
		wr(ADDR_CNT_CTRL0, 8'h90);
		wr(ADDR_CNT_CTRL1, 8'h11);
		rd(ADDR_CNT_CTRL1, v, 1);
		$display("test master done");
		for (int m = 0; m < NUM_METERS; m++)
			run_chk(m, (m == 4) ? 8'h80 : 8'(m % 4), rnd(), rnd(), (m < 4) ? 2 : 4, 0, 1);
		$display("test routing done");
		run_chk(0, 8'h04, rnd(), rnd(), 2, 0, 1);
		run_chk(5, 8'h09, rnd(), rnd(), 4, 0, 1);
		$display("test dither done");
		// armed data on a stopped counter refuses rewrites until overflow
		wr(ADDR_CNT_CTRL0, 8'h80);
		n = rnd();
		wr(VB, n);
		wr(ADDR_CMP_CTRL[0], 8'h10);
		wr(ADDR_CMP_CTRL[0], 8'h00);
		wr(VB, 8'h00);
		rd(ADDR_CMP_CTRL[0], v, 1);
		rd(VB, v, 1);
		wr(ADDR_CNT_CTRL0, 8'hb0);
		run_chk(0, 8'h00, n, mdl[VB + 16'h0001], 2, 1, 0);
		$display("test full count done");
		for (int k = 1; k < 4; k++) begin
			wr(ADDR_CNT_CTRL0, 8'h80);
			wr(ADDR_CNT_CTRL0, 8'h90 | 8'(k));
			run_chk(1, 8'h01, rnd(), rnd(), 2 << k, 0, 1);
		end
		$display("test prescaler done");
		wr(ADDR_CNT_CTRL1, 8'h00);
		wr(ADDR_CNT_CTRL1, 8'h18);
		run_chk(4, 8'h80, rnd(), rnd(), 8, 0, 1);
		$display("test external clock done");
		// master off clears both controls, armed flags and the pins
		wr(ADDR_CMP_CTRL[1], 8'h10);
		wr(ADDR_CNT_CTRL0, 8'h00);
		repeat (2) @(posedge mclk);
		#1 `CHK("pins after stop", 24'h0, pins)
		rd(ADDR_CNT_CTRL1, v, 1);
		rd(ADDR_CMP_CTRL[1], v, 1);
		$display("test master off done");
		close_out();
	end

	// watchdog, about a quarter above the longest expected run
	initial begin
		#475000;
		bad_count++;
		close_out();
	end
endmodule : mpc_meter_pwm_tb
